// [pkg/clm_pkg.sv]
// constants, register map and carrier types of the codec level, mute and
// input select block; shared by the design and its bench
package clm_pkg;

	// register offsets on the 8-bit control port
	localparam logic [7:0] REG_POWER  = 8'h02;
	localparam logic [7:0] REG_FMODE  = 8'h03;
	localparam logic [7:0] REG_MISC   = 8'h05;
	localparam logic [7:0] REG_CLOCK  = 8'h06;
	localparam logic [7:0] REG_RAMP   = 8'h0D;
	localparam logic [7:0] REG_CHMUTE = 8'h0E;
	localparam logic [7:0] REG_VOL0   = 8'h0F; // eight volume regs 0Fh..16h
	localparam logic [7:0] REG_MIX    = 8'h17;
	localparam logic [7:0] REG_MUTE_CONTROL_PIN  = 8'h18;
	localparam logic [7:0] REG_RXMUX  = 8'h1F;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_GPO0   = 8'h29; // seven pin regs 29h..2Fh

	// field positions
	localparam int MISC_HPF_EN  = 0;
	localparam int MISC_HOLD    = 1;
	localparam int MISC_FILT    = 2;
	localparam int MUTE_CONTROL_PIN_SW     = 0;
	localparam int MUTE_CONTROL_PIN_AUTO   = 1;
	localparam int RXMUX_RX_LSB = 0;
	localparam int RXMUX_TX_LSB = 3;
	localparam int STAT_OVF     = 0;

	// values after reset
	localparam logic       RST_POWER_DOWN = 1'h1;
	localparam logic [1:0] RST_SPEED      = 2'h0;
	localparam logic [2:0] RST_SRC_SEL    = 3'h0;
	localparam logic       RST_AUTO_MUTE  = 1'h1;

	// speed mode codes, oversampling ratios and top sample rates in kHz
	localparam logic [1:0] SPD_SINGLE = 2'h0;
	localparam logic [1:0] SPD_DOUBLE = 2'h1;
	localparam logic [1:0] SPD_QUAD   = 2'h2;
	localparam logic [7:0] OSR_SINGLE = 8'h80;
	localparam logic [7:0] OSR_DOUBLE = 8'h40;
	localparam logic [7:0] OSR_QUAD   = 8'h20;
	localparam logic [7:0] MAXR_SINGLE = 8'h32;
	localparam logic [7:0] MAXR_DOUBLE = 8'h64;
	localparam logic [7:0] MAXR_QUAD   = 8'hC0;

	// adc clip codes and limits in the 27-bit working width
	localparam logic [23:0] ADC_POS_CODE = 24'h7FFFFF;
	localparam logic [23:0] ADC_NEG_CODE = 24'h800000;
	localparam logic signed [26:0] ADC_POS_LIM = 27'sh07FFFFF;
	localparam logic signed [26:0] ADC_NEG_LIM = 27'sh7800000;
	localparam int HPF_SHIFT = 10;

	// attenuation in 0.125 dB units; volume code in 0.5 dB units
	localparam logic [9:0] ATT_MAX  = 10'h3F8;
	localparam logic [7:0] VOL_MAX  = 8'hFE;

	// ramp divider masks, counted in dac sample strobes
	localparam logic [3:0] RAMP_MASK1 = 4'h0;
	localparam logic [3:0] RAMP_MASK2 = 4'h3;
	localparam logic [3:0] RAMP_MASK3 = 4'hF;

	// shared pin function codes
	localparam logic [3:0] GPO_INPUT = 4'h0;
	localparam logic [3:0] GPO_LOW   = 4'h1;
	localparam logic [3:0] GPO_HIGH  = 4'h2;
	localparam logic [3:0] GPO_OVF   = 4'h3;
	localparam logic [3:0] GPO_PAIR0 = 4'h4; // 4..7: mute of pair 0..3
	localparam logic [3:0] GPO_ALL   = 4'h8;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} clm_bus_s;

	typedef struct packed {
		logic              power_down_bit;
		logic [1:0]        speed;
		logic              hpfEn;
		logic              hold;
		logic              filt;
		logic              clkSel;
		logic [1:0]        rampRate;
		logic [7:0]        chMute;
		logic [7:0][7:0]   vol;
		logic [3:0]        mix;
		logic              swMute;
		logic              autoMute;
		logic [6:0][3:0]   gpoFn;
		logic [2:0]        rxSel;
		logic [2:0]        txSel;
		logic              ovf;
		logic [7:0]        rdData;
		logic [7:0][9:0]   att;
		logic [3:0]        rampCnt;
		logic [1:0][35:0]  est;
		logic [1:0][23:0]  adcOut;
		logic              adcValid;
		logic [7:0][23:0]  dacOut;
		logic              rateOk;
		logic              rxData;
		logic              passOut;
		logic              mutecOut;
		logic              mutecOe;
		logic [6:0]        gpoOut;
		logic [6:0]        gpoOe;
	} clm_state_s;

endpackage

// [verilog/clm_codec_ctrl.sv]
// digital control of the codec: speed mode, adc clip and offset filter,
// dac volume ramp and mute, mute pin, shared pins, mixing, input select
// assumes one 20 MHz clock, inputs synchronous to it, and a control port
// master that never issues read and write strobes together
//
// Notes on behaviour
// - single-rate mode takes rates to 50 kHz at 128x oversampling.
// - double-rate mode takes rates to 100 kHz at 64x oversampling.
// - quad-rate mode takes rates to 192 kHz at 32x oversampling.
// - system clock is the recovered clock or the external reference.
// - adc samples leave as two's complement words.
// - adc clips to 7FFFFFh or 800000h and sets the overflow status bit.
// - any shared pin can show that an adc overflow occurred.
// - high-pass filter subtracts a dc estimate; it can be switched on or off.
// - offset hold freezes each channel's estimate and keeps subtracting it.
// - filter choice bit picks fast or slow roll-off in every mode.
// - each dac attenuates 0 to -127 dB in 0.5 dB steps.
// - volume ramps in 0.125 dB steps at the ramp rate field's pace.
// - a channel silence bit ramps that dac to -127 dB.
// - clearing the silence bit ramps back to the volume register value.
// - mute control pin floats at power-up and while power-down is set.
// - otherwise the pin follows software or goes high on zero data or clock error.
// - each unused shared pin can output a selected hardware mute signal.
// - channel mixing is applied separately to each dac pair.
// - an 8:2 selector feeds the receiver and the pass-through output.
// - two 3-bit fields in one register pick receiver and pass-through sources.
// - both selections start at the first digital audio input.
//
// Our own choices: the address-and-strobe port and the register addresses.

`timescale 1ns/10ps

module clm_codec_ctrl (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire clm_pkg::clm_bus_s bus,
	output logic [7:0]             rdData,
	input  wire logic [7:0]        rateKhz,
	output logic [7:0]             osrRatio,
	output logic [7:0]             maxRateKhz,
	output logic                   rateOk,
	output logic                   sysClkSel,
	input  wire logic              adcStrobe,
	input  wire logic [1:0][25:0]  adcIn,
	output logic [1:0][23:0]       adcOut,
	output logic                   adcValid,
	output logic                   adcOverflow,
	output logic                   filterSel,
	input  wire logic              dacStrobe,
	input  wire logic [7:0][23:0]  dacIn,
	output logic [7:0][23:0]       dacOut,
	output logic [7:0][9:0]        dacAtten,
	input  wire logic [7:0]        dacZero,
	input  wire logic              serialClkErr,
	output logic                   mutecOut,
	output logic                   mutecOe,
	input  wire logic              rxIn0,
	input  wire logic [6:0]        gpoIn,
	output logic [6:0]             gpoOut,
	output logic [6:0]             gpoOe,
	output logic                   rxData,
	output logic                   passOut
);

	clm_pkg::clm_state_s r;
	clm_pkg::clm_state_s n;

	// pick one side for a mixed output: zero, left, right or their mean
	function automatic logic [23:0] mixPick(input logic [1:0]  sel,
	                                        input logic [23:0] a,
	                                        input logic [23:0] b);
		logic [24:0] sum;
		sum = 25'($signed(a)) + 25'($signed(b));
		unique case (sel)
			2'h0: mixPick = 24'h000000;
			2'h1: mixPick = a;
			2'h2: mixPick = b;
			default: mixPick = sum[24:1];
		endcase
	endfunction

	// volume code to attenuation in 0.125 dB units, codes past -127 clamp
	function automatic logic [9:0] volToAtt(input logic [7:0] v);
		logic [7:0] c;
		c = (v > clm_pkg::VOL_MAX) ? clm_pkg::VOL_MAX : v;
		volToAtt = {c, 2'h0};
	endfunction

	// eight inputs: the dedicated one and the seven shared pins
	logic [7:0]         srcBus;
	logic               rampTick;
	logic [3:0]         rampMask;
	logic [9:0]         target;
	logic [7:0]         chSilent;
	logic signed [35:0] xs;
	logic signed [35:0] es;
	logic signed [35:0] df;
	logic signed [26:0] y;
	logic [2:0]         volIdx;
	logic [2:0]         gpoIdx;
	logic               hwMute;
	logic [7:0]         pairBits;

	assign srcBus = {gpoIn, rxIn0};

	always_comb begin
		n = r;
		rampTick = 1'b0;
		rampMask = clm_pkg::RAMP_MASK1;
		target = 10'h000;
		chSilent = 8'h00;
		xs = 36'sh0;
		es = 36'sh0;
		df = 36'sh0;
		y = 27'sh0;
		volIdx = 3'h0;
		gpoIdx = 3'h0;
		hwMute = 1'b0;
		pairBits = 8'h00;

		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				clm_pkg::REG_POWER:  n.power_down_bit = bus.wdata[0];
				clm_pkg::REG_FMODE:  n.speed = bus.wdata[1:0];
				clm_pkg::REG_MISC: begin
					n.hpfEn = bus.wdata[clm_pkg::MISC_HPF_EN];
					n.hold = bus.wdata[clm_pkg::MISC_HOLD];
					n.filt = bus.wdata[clm_pkg::MISC_FILT];
				end
				clm_pkg::REG_CLOCK:  n.clkSel = bus.wdata[0];
				clm_pkg::REG_RAMP:   n.rampRate = bus.wdata[1:0];
				clm_pkg::REG_CHMUTE: n.chMute = bus.wdata;
				clm_pkg::REG_MIX:    n.mix = bus.wdata[3:0];
				clm_pkg::REG_MUTE_CONTROL_PIN: begin
					n.swMute = bus.wdata[clm_pkg::MUTE_CONTROL_PIN_SW];
					n.autoMute = bus.wdata[clm_pkg::MUTE_CONTROL_PIN_AUTO];
				end
				clm_pkg::REG_RXMUX: begin
					n.rxSel = bus.wdata[clm_pkg::RXMUX_RX_LSB +: 3];
					n.txSel = bus.wdata[clm_pkg::RXMUX_TX_LSB +: 3];
				end
				default: begin
					if (bus.addr >= clm_pkg::REG_VOL0 &&
					    bus.addr < clm_pkg::REG_VOL0 + 8'h08) begin
						volIdx = 3'(bus.addr - clm_pkg::REG_VOL0);
						n.vol[volIdx] = bus.wdata;
					end
					if (bus.addr >= clm_pkg::REG_GPO0 &&
					    bus.addr < clm_pkg::REG_GPO0 + 8'h07) begin
						gpoIdx = 3'(bus.addr - clm_pkg::REG_GPO0);
						n.gpoFn[gpoIdx] = bus.wdata[3:0];
					end
				end
			endcase
		end

		// register reads; data stand in the following cycle only
		n.rdData = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				clm_pkg::REG_POWER:  n.rdData = {7'h00, r.power_down_bit};
				clm_pkg::REG_FMODE:  n.rdData = {6'h00, r.speed};
				clm_pkg::REG_MISC:   n.rdData = {5'h00, r.filt, r.hold, r.hpfEn};
				clm_pkg::REG_CLOCK:  n.rdData = {7'h00, r.clkSel};
				clm_pkg::REG_RAMP:   n.rdData = {6'h00, r.rampRate};
				clm_pkg::REG_CHMUTE: n.rdData = r.chMute;
				clm_pkg::REG_MIX:    n.rdData = {4'h0, r.mix};
				clm_pkg::REG_MUTE_CONTROL_PIN:  n.rdData = {6'h00, r.autoMute, r.swMute};
				clm_pkg::REG_RXMUX:  n.rdData = {2'h0, r.txSel, r.rxSel};
				clm_pkg::REG_STATUS: n.rdData = {7'h00, r.ovf};
				default: begin
					if (bus.addr >= clm_pkg::REG_VOL0 &&
					    bus.addr < clm_pkg::REG_VOL0 + 8'h08) begin
						volIdx = 3'(bus.addr - clm_pkg::REG_VOL0);
						n.rdData = r.vol[volIdx];
					end
					if (bus.addr >= clm_pkg::REG_GPO0 &&
					    bus.addr < clm_pkg::REG_GPO0 + 8'h07) begin
						gpoIdx = 3'(bus.addr - clm_pkg::REG_GPO0);
						n.rdData = {4'h0, r.gpoFn[gpoIdx]};
					end
				end
			endcase
			// reading status clears the sticky overflow; a new clip below wins
			if (bus.addr == clm_pkg::REG_STATUS)
				n.ovf = 1'b0;
		end

		// speed mode: ratio and rate ceiling; reserved code acts as single
		unique case (r.speed)
			clm_pkg::SPD_DOUBLE: n.rateOk = rateKhz <= clm_pkg::MAXR_DOUBLE;
			clm_pkg::SPD_QUAD:   n.rateOk = rateKhz <= clm_pkg::MAXR_QUAD;
			default:             n.rateOk = rateKhz <= clm_pkg::MAXR_SINGLE;
		endcase

		// adc: offset filter, then clip to 24 bits two's complement
		n.adcValid = adcStrobe;
		if (adcStrobe) begin
			for (int c = 0; c < 2; c++) begin
				xs = 36'($signed(adcIn[c]));
				es = 36'($signed(r.est[c]));
				df = (xs <<< clm_pkg::HPF_SHIFT) - es;
				// estimate tracks only while enabled and not held
				if (r.hpfEn && !r.hold)
					n.est[c] = 36'(es + (df >>> clm_pkg::HPF_SHIFT));
				// held estimate keeps being subtracted even with filter off
				if (r.hpfEn || r.hold)
					y = 27'(xs - (es >>> clm_pkg::HPF_SHIFT));
				else
					y = 27'(xs);
				if (y > clm_pkg::ADC_POS_LIM) begin
					n.adcOut[c] = clm_pkg::ADC_POS_CODE;
					n.ovf = 1'b1;
				end else if (y < clm_pkg::ADC_NEG_LIM) begin
					n.adcOut[c] = clm_pkg::ADC_NEG_CODE;
					n.ovf = 1'b1;
				end else begin
					n.adcOut[c] = y[23:0];
				end
			end
		end

		// ramp pace: 00 jumps at once, others step every 1, 4 or 16 samples
		unique case (r.rampRate)
			2'h1: rampMask = clm_pkg::RAMP_MASK1;
			2'h2: rampMask = clm_pkg::RAMP_MASK2;
			default: rampMask = clm_pkg::RAMP_MASK3;
		endcase
		if (dacStrobe) begin
			n.rampCnt = (r.rampCnt >= rampMask) ? 4'h0 : r.rampCnt + 4'h1;
			rampTick = r.rampCnt >= rampMask;
		end

		// per-channel attenuation moves toward volume or full mute
		for (int c = 0; c < 8; c++) begin
			target = r.chMute[c] ? clm_pkg::ATT_MAX
			                     : volToAtt(r.vol[c]);
			if (r.rampRate == 2'h0)
				n.att[c] = target;
			else if (rampTick && r.att[c] < target)
				n.att[c] = r.att[c] + 10'h001;
			else if (rampTick && r.att[c] > target)
				n.att[c] = r.att[c] - 10'h001;
			chSilent[c] = r.chMute[c] && r.att[c] == clm_pkg::ATT_MAX;
		end

		// mixing per pair: mix[3:2] picks channel A, mix[1:0] channel B
		if (dacStrobe) begin
			for (int p = 0; p < 4; p++) begin
				n.dacOut[2*p] = mixPick(r.mix[3:2], dacIn[2*p],
				                        dacIn[2*p+1]);
				n.dacOut[2*p+1] = mixPick(r.mix[1:0], dacIn[2*p],
				                          dacIn[2*p+1]);
			end
		end

		// mute control pin floats in power-down, reset value keeps it so
		n.mutecOe = !r.power_down_bit;
		n.mutecOut = !r.power_down_bit && (r.swMute || (r.autoMute &&
		             (&dacZero || serialClkErr)));

		// shared pins: input unless a function code makes them drive
		for (int g = 0; g < 7; g++) begin
			hwMute = 1'b0;
			// reduce only the chosen pair's two bits, not the whole byte
			if (r.gpoFn[g] >= clm_pkg::GPO_PAIR0 &&
			    r.gpoFn[g] < clm_pkg::GPO_ALL) begin
				pairBits = chSilent >>
				           (2 * (r.gpoFn[g] - clm_pkg::GPO_PAIR0));
				hwMute = &pairBits[1:0];
			end
			unique case (r.gpoFn[g])
				clm_pkg::GPO_INPUT: n.gpoOe[g] = 1'b0;
				clm_pkg::GPO_LOW:   n.gpoOe[g] = 1'b1;
				clm_pkg::GPO_HIGH:  n.gpoOe[g] = 1'b1;
				clm_pkg::GPO_OVF:   n.gpoOe[g] = 1'b1;
				default: n.gpoOe[g] = r.gpoFn[g] <= clm_pkg::GPO_ALL;
			endcase
			unique case (r.gpoFn[g])
				clm_pkg::GPO_HIGH: n.gpoOut[g] = 1'b1;
				clm_pkg::GPO_OVF:  n.gpoOut[g] = r.ovf;
				clm_pkg::GPO_ALL:  n.gpoOut[g] = &chSilent;
				default:           n.gpoOut[g] = hwMute;
			endcase
		end

		// 8:2 selector, both taps registered
		n.rxData = srcBus[r.rxSel];
		n.passOut = srcBus[r.txSel];
	end

	// one state register; reset holds constants only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.power_down_bit <= clm_pkg::RST_POWER_DOWN;
			r.speed <= clm_pkg::RST_SPEED;
			r.autoMute <= clm_pkg::RST_AUTO_MUTE;
			r.rxSel <= clm_pkg::RST_SRC_SEL;
			r.txSel <= clm_pkg::RST_SRC_SEL;
		end else begin
			r <= n;
		end
	end

	// outputs straight from state; ratio decode is a pure level
	always_comb begin
		unique case (r.speed)
			clm_pkg::SPD_DOUBLE: begin
				osrRatio = clm_pkg::OSR_DOUBLE;
				maxRateKhz = clm_pkg::MAXR_DOUBLE;
			end
			clm_pkg::SPD_QUAD: begin
				osrRatio = clm_pkg::OSR_QUAD;
				maxRateKhz = clm_pkg::MAXR_QUAD;
			end
			default: begin
				osrRatio = clm_pkg::OSR_SINGLE;
				maxRateKhz = clm_pkg::MAXR_SINGLE;
			end
		endcase
	end

	assign rdData      = r.rdData;
	assign rateOk      = r.rateOk;
	assign sysClkSel   = r.clkSel;
	assign adcOut      = r.adcOut;
	assign adcValid    = r.adcValid;
	assign adcOverflow = r.ovf;
	assign filterSel   = r.filt;
	assign dacOut      = r.dacOut;
	assign dacAtten    = r.att;
	assign mutecOut    = r.mutecOut;
	assign mutecOe     = r.mutecOe;
	assign gpoOut      = r.gpoOut;
	assign gpoOe       = r.gpoOe;
	assign rxData      = r.rxData;
	assign passOut     = r.passOut;

endmodule

// [testbench/clm_codec_checker.sv]
// assertions for the codec control block, seen at its ports only
// assumes clm_pkg is compiled first; bound into clm_codec_ctrl
`timescale 1ns/10ps
module clm_codec_checker (
	input wire logic              clk,
	input wire logic              nrst,
	input wire clm_pkg::clm_bus_s bus,
	input wire logic [7:0]        rdData,
	input wire logic [7:0]        rateKhz,
	input wire logic [7:0]        osrRatio,
	input wire logic [7:0]        maxRateKhz,
	input wire logic              rateOk,
	input wire logic              sysClkSel,
	input wire logic              adcStrobe,
	input wire logic [1:0][25:0]  adcIn,
	input wire logic [1:0][23:0]  adcOut,
	input wire logic              adcValid,
	input wire logic              adcOverflow,
	input wire logic              filterSel,
	input wire logic              dacStrobe,
	input wire logic [7:0][23:0]  dacOut,
	input wire logic              mutecOe
);
	logic clkWr, miscWr, pwrWr, statRd;

	// decoded control port accesses, so $past sees plain signals
	assign clkWr  = bus.wr && bus.addr == clm_pkg::REG_CLOCK;
	assign miscWr = bus.wr && bus.addr == clm_pkg::REG_MISC;
	assign pwrWr  = bus.wr && bus.addr == clm_pkg::REG_POWER;
	assign statRd = bus.rd && bus.addr == clm_pkg::REG_STATUS;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_read_slot: assert property (
		!$past(bus.rd) |-> rdData == 8'h00) else $error("stray read data");
	a_mode_table: assert property (
		(osrRatio == 8'h80 && maxRateKhz == 8'h32) ||
		(osrRatio == 8'h40 && maxRateKhz == 8'h64) ||
		(osrRatio == 8'h20 && maxRateKhz == 8'hC0)) else $error("bad mode");
	// guard on $past(nrst): the flag is held at zero through reset
	a_rate_check: assert property (
		$past(nrst) |-> rateOk == ($past(rateKhz) <= $past(maxRateKhz)))
		else $error("rate check wrong");
	a_clk_source: assert property (
		$changed(sysClkSel) |-> $past(clkWr)) else $error("clock sel moved");
	a_adc_valid: assert property (
		adcStrobe |=> adcValid) else $error("no adc valid");
	a_clip_high: assert property (
		adcStrobe && $signed(adcIn[0]) > clm_pkg::ADC_POS_LIM |=>
		adcOut[0] == clm_pkg::ADC_POS_CODE && adcOverflow)
		else $error("no positive clip");
	a_clip_low: assert property (
		adcStrobe && $signed(adcIn[1]) < clm_pkg::ADC_NEG_LIM |=>
		adcOut[1] == clm_pkg::ADC_NEG_CODE && adcOverflow)
		else $error("no negative clip");
	a_ovf_clear: assert property (
		$fell(adcOverflow) |-> $past(statRd)) else $error("flag lost");
	a_filter_bit: assert property (
		!$stable(filterSel) |-> $past(miscWr)) else $error("filter moved");
	// the pin wakes two edges after the power write; one edge is also accepted
	a_pin_wake: assert property (
		$rose(mutecOe) |-> $past(pwrWr) || $past(pwrWr, 2))
		else $error("mute pin woke alone");
	a_mix_hold: assert property (
		!$past(dacStrobe) |-> $stable(dacOut)) else $error("dac out moved");

	c_clip: cover property (adcOverflow);
	c_quad: cover property (osrRatio == 8'h20);
	c_pin: cover property (mutecOe);
endmodule

bind clm_codec_ctrl clm_codec_checker i_clm_codec_checker (
	.clk, .nrst, .bus, .rdData, .rateKhz, .osrRatio, .maxRateKhz, .rateOk,
	.sysClkSel, .adcStrobe, .adcIn, .adcOut, .adcValid, .adcOverflow,
	.filterSel, .dacStrobe, .dacOut, .mutecOe);

// [testbench/clm_audio_partner.sv]
// audio sources and external mute circuit facing the block
// assumes the bench sets the source pattern; mute line pulled low
`timescale 1ns/10ps
module clm_audio_partner (
	input  wire logic [7:0] pat,
	input  wire logic       mutecOut,
	input  wire logic       mutecOe,
	input  wire logic [6:0] gpoOut,
	input  wire logic [6:0] gpoOe,
	output logic            rxIn0,
	output logic [6:0]      gpoIn,
	output logic            muteLine
);
	// source 0 on the dedicated input, 1..7 on shared pins
	assign rxIn0 = pat[0];
	// a driven shared pin shows the block's level, not the source
	assign gpoIn = (gpoOe & gpoOut) | (~gpoOe & pat[7:1]);
	// floating pin falls to the pull-down, never keeps its last level
	assign muteLine = mutecOe ? mutecOut : 1'b0;
endmodule

// [testbench/clm_codec_ctrl_tb.sv]
// self-checking bench for the codec control block
// assumes clm_pkg, the block, its checker and the source model
`timescale 1ns/10ps
module clm_codec_ctrl_tb;
	logic              clk, nrst, rateOk, sysClkSel, adcStrobe, adcValid;
	logic              adcOverflow, filterSel, dacStrobe, serialClkErr;
	logic              mutecOut, mutecOe, rxIn0, rxData, passOut, muteLine;
	logic [7:0]        rdData, rateKhz, osrRatio, maxRateKhz, pat, dacZero;
	logic [6:0]        gpoIn, gpoOut, gpoOe;
	logic [1:0][25:0]  adcIn;
	logic [1:0][23:0]  adcOut;
	logic [7:0][23:0]  dacIn, dacOut;
	logic [7:0][9:0]   dacAtten;
	clm_pkg::clm_bus_s bus;
	int                num_errors, n_compared;

	clm_codec_ctrl i_clm_codec_ctrl (.clk, .nrst, .bus, .rdData, .rateKhz,
		.osrRatio, .maxRateKhz, .rateOk, .sysClkSel, .adcStrobe, .adcIn,
		.adcOut, .adcValid, .adcOverflow, .filterSel, .dacStrobe, .dacIn,
		.dacOut, .dacAtten, .dacZero, .serialClkErr, .mutecOut, .mutecOe,
		.rxIn0, .gpoIn, .gpoOut, .gpoOe, .rxData, .passOut);
	clm_audio_partner i_clm_audio_partner (.pat, .mutecOut, .mutecOe,
		.gpoOut, .gpoOe, .rxIn0, .gpoIn, .muteLine);

	task automatic chk(input string nm, input logic [23:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// strobes drop on the next edge, so calls never collide
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e, input string nm);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus.rd <= 1'b0;
		#1 chk(nm, rdData, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stb(input bit dac);
		@(posedge clk) {dacStrobe, adcStrobe} <= dac ? 2'b10 : 2'b01;
		@(posedge clk) {dacStrobe, adcStrobe} <= 2'b00;
		tick(1);
	endtask

	task automatic t_reset;
		chk("osr", osrRatio, clm_pkg::OSR_SINGLE);
		chk("mute line", muteLine, 1'b0);
		rd(clm_pkg::REG_RXMUX, 8'h00, "src sel");
		rd(clm_pkg::REG_POWER, 8'h01, "pdn");
		rd(8'h40, 8'h00, "unmapped");
		wr(clm_pkg::REG_CLOCK, 8'h01);
		tick(1);
		chk("clk sel", sysClkSel, 1'b1);
	endtask
	task automatic t_speed;
		logic [7:0] mx [3] = '{8'h32, 8'h64, 8'hC0};
		for (int m = 0; m < 3; m++) begin
			wr(clm_pkg::REG_FMODE, 8'(m));
			tick(2);
			chk("osr", osrRatio, 8'h80 >> m);
			chk("max", maxRateKhz, mx[m]);
			chk("rate ok", rateOk, m != 0);
		end
		@(posedge clk) rateKhz <= 8'hC1;
		tick(2);
		chk("rate hi", rateOk, 1'b0);
		@(posedge clk) rateKhz <= 8'hC0;
		tick(2);
		chk("rate edge", rateOk, 1'b1);
	endtask
	task automatic t_select;
		for (int s = 0; s < 8; s++) begin
			wr(clm_pkg::REG_RXMUX, {2'b00, 3'(7 - s), 3'(s)});
			for (int v = 0; v < 2; v++) begin
				@(posedge clk) pat <= v ? ~(8'h01 << s) : 8'h01 << s;
				tick(2);
				chk("rx", rxData, v == 0);
				chk("pass", passOut, v == 1);
			end
		end
	endtask
	task automatic t_adc;
		logic [23:0] o;
		wr(clm_pkg::REG_MISC, 8'h04);
		@(posedge clk) adcIn <= {26'h3700000, 26'h0900000};
		stb(0);
		chk("pos clip", adcOut[0], 24'h7FFFFF);
		chk("neg clip", adcOut[1], 24'h800000);
		chk("ovf flag", adcOverflow, 1'b1);
		chk("filter", filterSel, 1'b1);
		wr(clm_pkg::REG_GPO0, clm_pkg::GPO_OVF);
		tick(2);
		chk("ovf pin", gpoIn[0], 1'b1);
		rd(clm_pkg::REG_STATUS, 8'h01, "ovf");
		rd(clm_pkg::REG_STATUS, 8'h00, "ovf clr");
		@(posedge clk) adcIn <= {26'h3FFFFFE, 26'h0012345};
		stb(0);
		chk("neg word", adcOut[1], 24'hFFFFFE);
		chk("pos word", adcOut[0], 24'h012345);
		wr(clm_pkg::REG_MISC, 8'h01);
		@(posedge clk) adcIn <= {2{26'h0100000}};
		repeat (40) stb(0);
		chk("hpf", adcOut[0] < 24'h100000, 1'b1);
		wr(clm_pkg::REG_MISC, 8'h02);
		stb(0);
		o = adcOut[0];
		stb(0);
		chk("hold", adcOut[0], o);
		chk("held sub", o < 24'h100000, 1'b1);
		wr(clm_pkg::REG_MISC, 8'h03);
		stb(0);
		chk("hold on", adcOut[0], o);
	endtask
	task automatic t_volume;
		wr(clm_pkg::REG_RAMP, 8'h00);
		wr(clm_pkg::REG_VOL0, 8'hFF);
		stb(1);
		chk("att clamp", dacAtten[0], 10'h3F8);
		wr(clm_pkg::REG_VOL0, 8'h10);
		stb(1);
		chk("att", dacAtten[0], 10'h040);
		wr(clm_pkg::REG_CHMUTE, 8'h01);
		stb(1);
		chk("mute att", dacAtten[0], 10'h3F8);
		wr(clm_pkg::REG_RAMP, 8'h01);
		wr(clm_pkg::REG_CHMUTE, 8'h00);
		stb(1);
		chk("ramp 1", dacAtten[0], 10'h3F7);
		stb(1);
		chk("ramp 2", dacAtten[0], 10'h3F6);
		wr(clm_pkg::REG_RAMP, 8'h02);
		repeat (3) stb(1);
		chk("slow hold", dacAtten[0], 10'h3F6);
		stb(1);
		chk("slow step", dacAtten[0], 10'h3F5);
		wr(clm_pkg::REG_RAMP, 8'h00);
		stb(1);
		chk("unmute", dacAtten[0], 10'h040);
	endtask
	task automatic t_mix;
		logic [7:0] c [3] = '{8'h06, 8'h09, 8'h00};
		for (int k = 0; k < 8; k++)
			dacIn[k] <= 24'(24'h111111 * (k + 1));
		for (int i = 0; i < 3; i++) begin
			wr(clm_pkg::REG_MIX, c[i]);
			stb(1);
			for (int k = 0; k < 8; k++)
				chk("mix", dacOut[k], i == 2 ? 24'h0 :
					24'(24'h111111 * ((i == 1 ? k ^ 1 : k) + 1)));
		end
		wr(clm_pkg::REG_MIX, 8'h0F);
		stb(1);
		chk("mean a", dacOut[0], 24'h199999);
		chk("mean b", dacOut[7], 24'hFFFFFF);
	endtask
	task automatic t_mute;
		wr(clm_pkg::REG_CHMUTE, 8'hFF); // dacs silent before the pin
		stb(1);
		wr(clm_pkg::REG_GPO0 + 8'h01, clm_pkg::GPO_ALL);
		wr(clm_pkg::REG_GPO0 + 8'h02, clm_pkg::GPO_HIGH);
		wr(clm_pkg::REG_GPO0 + 8'h03, clm_pkg::GPO_PAIR0);
		wr(clm_pkg::REG_GPO0 + 8'h04, clm_pkg::GPO_LOW);
		tick(2);
		chk("gpo", {gpoIn[4:1], gpoOe[4:1]}, 8'h7F);
		wr(clm_pkg::REG_POWER, 8'h00);
		tick(2);
		chk("mute idle", {mutecOe, muteLine}, 2'b10);
		@(posedge clk) serialClkErr <= 1'b1;
		tick(2);
		chk("clk err", muteLine, 1'b1);
		@(posedge clk) {serialClkErr, dacZero} <= {1'b0, 8'h7F};
		tick(2);
		chk("part zero", muteLine, 1'b0);
		@(posedge clk) dacZero <= 8'hFF;
		tick(2);
		chk("all zero", muteLine, 1'b1);
		@(posedge clk) dacZero <= 8'h00;
		wr(clm_pkg::REG_MUTE_CONTROL_PIN, 8'h01);
		tick(2);
		chk("sw mute", muteLine, 1'b1);
		wr(clm_pkg::REG_POWER, 8'h01);
		tick(2);
		chk("pdn float", {mutecOe, muteLine}, 2'b00);
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// main sequence; mix runs before mute, whose silence bits reach dacAtten but never dacOut
	initial begin
		{nrst, adcStrobe, dacStrobe, serialClkErr} = 4'h0;
		{bus, pat, dacZero, adcIn, dacIn} = '0;
		rateKhz = 8'h60;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		tick(1);
		t_reset;
		t_speed;
		t_select;
		t_adc;
		t_volume;
		t_mix;
		t_mute;
		close_out;
	end
	// hang guard, far beyond the expected run of some three hundred and fifty cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out;
	end
endmodule
